/* design/card_irq_select_buffer.sv */
// smart card host control slice: interrupts, selection, byte buffer
`timescale 1ns/1ps
`default_nettype none


// -------------------------------------------------------------
// transmit byte fifo
// -------------------------------------------------------------
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
   localparam logic [AW:0] ONE_COUNT  = (AW+1)'(1);
   localparam logic [AW-1:0] ONE_PTR  = AW'(1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             push;
   logic             pop;

   assign in_ready  = (count_r != FULL_COUNT);
   assign out_valid = (count_r != '0);
   assign out_data  = mem[rd_ptr_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + ONE_PTR;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + ONE_PTR;
         end
         if (push && !pop) begin
            count_r <= count_r + ONE_COUNT;
         end else if (pop && !push) begin
            count_r <= count_r - ONE_COUNT;
         end
      end
   end
endmodule

// -------------------------------------------------------------
// top of the slice
// -------------------------------------------------------------
module card_irq_select_buffer #(
   parameter int FIFO_DEPTH = 32
) (
   input  wire logic                       core_clk,
   input  wire logic                       rst,
   input  wire card_uart_pkg::sfr_req_s    sfr_req,
   output logic [7:0]                      sfr_rdata_r,
   input  wire logic                       ev_current_ovf,
   input  wire logic                       ev_voltage_err,
   input  wire logic                       ev_wait_timeout,
   input  wire card_uart_pkg::shifter_ev_s shifter_ev,
   input  wire logic                       inverse_convention,
   input  wire logic                       rx_start_edge,
   input  wire logic                       etu_tick,
   input  wire logic [8:0]                 guard_time_value,
   output logic                            tx_valid_r,
   input  wire logic                       tx_ready,
   output logic [7:0]                      tx_byte_r,
   output logic                            tx_buffer_empty_flag_r,
   output logic                            irq_r,
   output card_uart_pkg::irq_src_e         irq_code_r,
   input  wire logic                       prescaler_source_clock,
   input  wire logic                       alt_port_bit,
   output logic                            alt_card_clock_pin_r
);

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   // inverse convention: reversed order and inverted levels; direct passes through
   function automatic logic [7:0] conv_order(input logic [7:0] b, input logic inv);
      logic [7:0] r;
      r = b;
      if (inv) begin
         for (int i = 0; i < 8; i++) begin
            r[i] = ~b[7-i];
         end
      end
      return r;
   endfunction

   function automatic card_uart_pkg::irq_src_e top_source(input logic [7:0] act);
      card_uart_pkg::irq_src_e s;
      s = card_uart_pkg::SRC_NONE;
      if (act[card_uart_pkg::IRQ_TBE])      s = card_uart_pkg::SRC_TBE;
      else if (act[card_uart_pkg::IRQ_OVF]) s = card_uart_pkg::SRC_OVF;
      else if (act[card_uart_pkg::IRQ_VLT]) s = card_uart_pkg::SRC_VLT;
      else if (act[card_uart_pkg::IRQ_WTO]) s = card_uart_pkg::SRC_WTO;
      else if (act[card_uart_pkg::IRQ_TXC]) s = card_uart_pkg::SRC_TXC;
      else if (act[card_uart_pkg::IRQ_RXC]) s = card_uart_pkg::SRC_RXC;
      else if (act[card_uart_pkg::IRQ_PAR]) s = card_uart_pkg::SRC_PAR;
      return s;
   endfunction

   logic [7:0]  sel_r;
   logic [7:0]  ier_r;
   logic [7:0]  pend_r;
   logic [7:0]  rx_buf_r;
   logic [7:0]  ev_set;
   logic [7:0]  act;
   logic        set_one;
   logic        rd_ident;
   logic        wr_ier;
   logic        wr_buf;
   logic        bgt_en_d_r;
   logic [8:0]  bgt_cnt_r;
   logic        bgt_hold;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic        fifo_pop;
   logic [7:0]  fifo_out_data;
   card_uart_pkg::tx_state_e tx_state_r;
   logic [2:0]  sends_r;
   logic [2:0]  send_limit;
   logic        tx_take;
   logic        tx_last_fail;
   logic        tx_ok;
   logic        src_d_r;
   logic [2:0]  div_cnt_r;
   logic        prescaled;

   // -------------------------------------------------------------
   // register access decode
   // -------------------------------------------------------------
   assign set_one  = sel_r[card_uart_pkg::SEL_SET_BIT];
   assign rd_ident = sfr_req.rd && sfr_req.addr == card_uart_pkg::ADDR_IER && !set_one;
   assign wr_ier   = sfr_req.wr && sfr_req.addr == card_uart_pkg::ADDR_IER && set_one;
   assign wr_buf   = sfr_req.wr && sfr_req.addr == card_uart_pkg::ADDR_BUF;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sel_r <= card_uart_pkg::SEL_RESET;
      end else if (sfr_req.wr && sfr_req.addr == card_uart_pkg::ADDR_SEL) begin
         sel_r <= sfr_req.wdata & card_uart_pkg::SEL_WMASK;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         ier_r <= card_uart_pkg::IER_RESET;
      end else if (wr_ier) begin
         ier_r <= sfr_req.wdata & card_uart_pkg::IER_WMASK;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sfr_rdata_r <= card_uart_pkg::BYTE_ZERO;
      end else if (sfr_req.rd) begin
         case (sfr_req.addr)
            card_uart_pkg::ADDR_BUF: sfr_rdata_r <= rx_buf_r;
            card_uart_pkg::ADDR_SEL: sfr_rdata_r <= sel_r;
            card_uart_pkg::ADDR_IER: sfr_rdata_r <= set_one ? ier_r : pend_r;
            default:                 sfr_rdata_r <= card_uart_pkg::BYTE_ZERO;
         endcase
      end
   end

   // -------------------------------------------------------------
   // pending flags and interrupt output
   // -------------------------------------------------------------
   always_comb begin
      ev_set = card_uart_pkg::BYTE_ZERO;
      ev_set[card_uart_pkg::IRQ_TBE] = tx_take && tx_state_r == card_uart_pkg::TX_IDLE
                                       && sends_r == '0;
      ev_set[card_uart_pkg::IRQ_OVF] = ev_current_ovf;
      ev_set[card_uart_pkg::IRQ_VLT] = ev_voltage_err;
      ev_set[card_uart_pkg::IRQ_WTO] = ev_wait_timeout;
      ev_set[card_uart_pkg::IRQ_TXC] = tx_ok;
      ev_set[card_uart_pkg::IRQ_RXC] = shifter_ev.rx_valid;
      ev_set[card_uart_pkg::IRQ_PAR] = tx_last_fail
                                       || (shifter_ev.rx_valid && shifter_ev.rx_parity_err);
   end

   // an event landing on the read cycle survives: set is applied after clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pend_r <= card_uart_pkg::IDENT_RESET;
      end else begin
         pend_r <= (rd_ident ? card_uart_pkg::BYTE_ZERO : pend_r) | ev_set;
      end
   end

   assign act = pend_r & ier_r;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         irq_r      <= 1'b0;
         irq_code_r <= card_uart_pkg::SRC_NONE;
      end else begin
         irq_r      <= |act;
         irq_code_r <= top_source(act);
      end
   end

   // -------------------------------------------------------------
   // receive byte
   // -------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rx_buf_r <= card_uart_pkg::BYTE_ZERO;
      end else if (shifter_ev.rx_valid) begin
         rx_buf_r <= conv_order(shifter_ev.rx_raw, inverse_convention);
      end
   end

   // -------------------------------------------------------------
   // block guard time
   // -------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bgt_en_d_r <= 1'b0;
         bgt_cnt_r  <= card_uart_pkg::GUARD_ZERO;
      end else begin
         bgt_en_d_r <= sel_r[card_uart_pkg::SEL_BGT_BIT];
         if ((sel_r[card_uart_pkg::SEL_BGT_BIT] && !bgt_en_d_r) || rx_start_edge) begin
            bgt_cnt_r <= guard_time_value;
         end else if (etu_tick && bgt_cnt_r != card_uart_pkg::GUARD_ZERO) begin
            bgt_cnt_r <= bgt_cnt_r - 9'h001;
         end
      end
   end

   // counter only matters while enabled, so clearing the bit frees the line at once
   assign bgt_hold = sel_r[card_uart_pkg::SEL_BGT_BIT]
                     && bgt_cnt_r != card_uart_pkg::GUARD_ZERO;

   // -------------------------------------------------------------
   // transmit path with character repetition
   // -------------------------------------------------------------
   // a full fifo silently drops the write; software watches the empty flag
   byte_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .core_clk  (core_clk),
      .rst       (rst),
      .in_valid  (wr_buf),
      .in_ready  (fifo_in_ready),
      .in_data   (conv_order(sfr_req.wdata, inverse_convention)),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out_data)
   );

   assign send_limit   = sel_r[card_uart_pkg::SEL_REP_BIT] ? card_uart_pkg::SEND_LIMIT_SHORT
                                                           : card_uart_pkg::SEND_LIMIT_LONG;
   assign tx_take      = tx_valid_r && tx_ready;
   assign tx_last_fail = tx_state_r == card_uart_pkg::TX_WAIT && shifter_ev.tx_nack
                         && sends_r == send_limit;
   assign tx_ok        = tx_state_r == card_uart_pkg::TX_WAIT && shifter_ev.tx_done
                         && !shifter_ev.tx_nack;
   assign fifo_pop     = tx_state_r == card_uart_pkg::TX_IDLE && !tx_valid_r
                         && fifo_out_valid && !bgt_hold;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_state_r <= card_uart_pkg::TX_IDLE;
         tx_valid_r <= 1'b0;
         tx_byte_r  <= card_uart_pkg::BYTE_ZERO;
         sends_r    <= '0;
      end else begin
         case (tx_state_r)
            card_uart_pkg::TX_IDLE: begin
               if (fifo_pop) begin
                  tx_valid_r <= 1'b1;
                  tx_byte_r  <= fifo_out_data;
                  sends_r    <= '0;
               end else if (tx_take) begin
                  tx_valid_r <= 1'b0;
                  tx_state_r <= card_uart_pkg::TX_WAIT;
                  sends_r    <= card_uart_pkg::SEND_FIRST;
               end
            end
            card_uart_pkg::TX_WAIT: begin
               if (tx_take) begin
                  tx_valid_r <= 1'b0;
                  sends_r    <= sends_r + 3'h1;
               end else if (shifter_ev.tx_nack) begin
                  if (sends_r == send_limit) begin
                     tx_state_r <= card_uart_pkg::TX_IDLE;
                     sends_r    <= '0;
                  end else if (!bgt_hold) begin
                     tx_valid_r <= 1'b1;
                  end
               end else if (shifter_ev.tx_done) begin
                  tx_state_r <= card_uart_pkg::TX_IDLE;
                  sends_r    <= '0;
               end
            end
            default: tx_state_r <= card_uart_pkg::TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_buffer_empty_flag_r <= 1'b1;
      end else begin
         tx_buffer_empty_flag_r <= fifo_in_ready;
      end
   end

   // -------------------------------------------------------------
   // alternate card clock
   // -------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (rst) begin
         src_d_r   <= 1'b0;
         div_cnt_r <= '0;
      end else begin
         src_d_r <= prescaler_source_clock;
         if (prescaler_source_clock && !src_d_r) begin
            div_cnt_r <= div_cnt_r + 3'h1;
         end
      end
   end

   always_comb begin
      case (sel_r[card_uart_pkg::SEL_DIV_HI:card_uart_pkg::SEL_DIV_LO])
         card_uart_pkg::DIV_1: prescaled = src_d_r;
         card_uart_pkg::DIV_2: prescaled = div_cnt_r[0];
         card_uart_pkg::DIV_4: prescaled = div_cnt_r[1];
         card_uart_pkg::DIV_8: prescaled = div_cnt_r[2];
         default:              prescaled = src_d_r;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         alt_card_clock_pin_r <= 1'b0;
      end else begin
         alt_card_clock_pin_r <= sel_r[card_uart_pkg::SEL_ROUTE_BIT] ? prescaled
                                                                    : alt_port_bit;
      end
   end

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   tbe_first_a: assert property (act[card_uart_pkg::IRQ_TBE] |=> irq_code_r == card_uart_pkg::SRC_TBE && irq_r) else $error("buffer empty not first");
   ovf_over_tx_a: assert property ((act[card_uart_pkg::IRQ_OVF] && !act[card_uart_pkg::IRQ_TBE]) |=> irq_code_r == card_uart_pkg::SRC_OVF) else $error("overflow order wrong");
   masked_quiet_a: assert property ((act == card_uart_pkg::BYTE_ZERO) |=> !irq_r) else $error("masked flag raised irq");
   ident_clear_a: assert property ((rd_ident && ev_set == card_uart_pkg::BYTE_ZERO) |=> pend_r == card_uart_pkg::BYTE_ZERO) else $error("identification read did not clear");
   ier_hidden_a: assert property ((sfr_req.wr && sfr_req.addr == card_uart_pkg::ADDR_IER && !set_one) |=> $stable(ier_r)) else $error("enable written in wrong set");
   ier_view_a: assert property ((sfr_req.rd && sfr_req.addr == card_uart_pkg::ADDR_IER && set_one) |=> sfr_rdata_r == $past(ier_r)) else $error("enable not visible");
   guard_load_a: assert property ((sel_r[card_uart_pkg::SEL_BGT_BIT] && !bgt_en_d_r && !rx_start_edge) |=> bgt_cnt_r == $past(guard_time_value)) else $error("guard value not loaded");
   guard_hold_a: assert property ((bgt_hold && !tx_valid_r) |=> !tx_valid_r) else $error("sent inside guard time");
   last_fail_a: assert property (tx_last_fail |=> pend_r[card_uart_pkg::IRQ_PAR] && tx_state_r == card_uart_pkg::TX_IDLE && !tx_valid_r) else $error("last repetition not ended");
   send_cap_a: assert property (sends_r <= send_limit) else $error("too many transmissions");
   rx_order_a: assert property (shifter_ev.rx_valid |=> rx_buf_r == conv_order($past(shifter_ev.rx_raw), $past(inverse_convention)) && pend_r[card_uart_pkg::IRQ_RXC]) else $error("received byte wrong");
   port_route_a: assert property (!sel_r[card_uart_pkg::SEL_ROUTE_BIT] |=> alt_card_clock_pin_r == $past(alt_port_bit)) else $error("pin not following port");

   retry_seen_c: cover property (tx_state_r == card_uart_pkg::TX_WAIT && shifter_ev.tx_nack ##[1:50] tx_ok);
   last_fail_c: cover property (tx_last_fail);
   guard_block_c: cover property (bgt_hold && fifo_out_valid);
   fifo_full_c: cover property (!fifo_in_ready && wr_buf);
endmodule

`default_nettype wire

/* inc/card_uart_pkg.sv */
// constants and carrier types for the smart card host control slice
package card_uart_pkg;

   // -------------------------------------------------------------
   // special-function addresses
   // -------------------------------------------------------------
   localparam logic [7:0] ADDR_BUF = 8'h0aa;
   localparam logic [7:0] ADDR_SEL = 8'h0ab;
   localparam logic [7:0] ADDR_IER = 8'h0ae;

   // -------------------------------------------------------------
   // reset values and writable masks
   // -------------------------------------------------------------
   localparam logic [7:0] SEL_RESET   = 8'h08;
   localparam logic [7:0] IER_RESET   = 8'h00;
   localparam logic [7:0] IDENT_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO   = 8'h00;
   localparam logic [7:0] SEL_WMASK   = 8'h5f;
   localparam logic [7:0] IER_WMASK   = 8'hbf;

   // -------------------------------------------------------------
   // selection register fields
   // -------------------------------------------------------------
   localparam int SEL_BGT_BIT   = 6;
   localparam int SEL_REP_BIT   = 4;
   localparam int SEL_DIV_HI    = 3;
   localparam int SEL_DIV_LO    = 2;
   localparam int SEL_ROUTE_BIT = 1;
   localparam int SEL_SET_BIT   = 0;

   localparam logic [1:0] DIV_1 = 2'h0;
   localparam logic [1:0] DIV_2 = 2'h1;
   localparam logic [1:0] DIV_4 = 2'h2;
   localparam logic [1:0] DIV_8 = 2'h3;

   // -------------------------------------------------------------
   // interrupt bit positions (enable and identification share them)
   // -------------------------------------------------------------
   localparam int IRQ_TBE = 7;
   localparam int IRQ_OVF = 5;
   localparam int IRQ_VLT = 4;
   localparam int IRQ_WTO = 3;
   localparam int IRQ_TXC = 2;
   localparam int IRQ_RXC = 1;
   localparam int IRQ_PAR = 0;

   // transmissions allowed before a parity error is reported
   localparam logic [2:0] SEND_LIMIT_LONG  = 3'h5;
   localparam logic [2:0] SEND_LIMIT_SHORT = 3'h4;
   localparam logic [2:0] SEND_FIRST       = 3'h1;

   localparam logic [8:0] GUARD_ZERO = 9'h000;

   typedef enum logic [2:0] {
      SRC_NONE = 3'b000,
      SRC_TBE  = 3'b001,
      SRC_OVF  = 3'b010,
      SRC_VLT  = 3'b011,
      SRC_WTO  = 3'b100,
      SRC_TXC  = 3'b101,
      SRC_RXC  = 3'b110,
      SRC_PAR  = 3'b111
   } irq_src_e;

   typedef enum logic {
      TX_IDLE = 1'b0,
      TX_WAIT = 1'b1
   } tx_state_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sfr_req_s;

   typedef struct packed {
      logic       tx_done;
      logic       tx_nack;
      logic       rx_valid;
      logic       rx_parity_err;
      logic [7:0] rx_raw;
   } shifter_ev_s;

endpackage

/* sim/card_shifter_model.sv */
// behavioural card side of the transmit byte handshake
`timescale 1ns/1ps
`default_nettype none
module card_shifter_model (
   input  wire logic       core_clk,
   input  wire logic       rst,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_byte,
   input  wire logic [2:0] nacks,
   output logic            tx_ready,
   output logic            tx_done,
   output logic            tx_nack,
   output logic      [7:0] got,
   output logic      [7:0] tries
);
   logic       busy;
   logic [2:0] nacked;
   // ready lags valid a cycle, so the offer must stand
   always_ff @(posedge core_clk) begin
      tx_done  <= 1'b0;
      tx_nack  <= 1'b0;
      tx_ready <= 1'b0;
      if (rst) begin
         busy   <= 1'b0;
         nacked <= 3'h0;
         got    <= 8'h00;
         tries  <= 8'h00;
      end else if (!busy) begin
         tx_ready <= tx_valid && !tx_ready;
         busy     <= tx_valid && tx_ready;
         if (tx_valid && tx_ready) begin
            got   <= tx_byte;
            tries <= tries + 8'h01;
         end
      end else begin
         busy    <= 1'b0;
         tx_nack <= nacked < nacks;
         tx_done <= nacked >= nacks;
         nacked  <= (nacked < nacks) ? nacked + 3'h1 : 3'h0;
      end
   end
endmodule
`default_nettype wire

/* sim/card_irq_select_buffer_bench.sv */
// self-checking bench for the host control slice
`timescale 1ns/1ps
`default_nettype none
module card_irq_select_buffer_bench;
   logic                       core_clk, rst, ovf, vlt, wto, rxv, rxp, inv, tick;
   logic                       txv, txr, tbe, irq, pin, done, nack;
   logic                       rse, src, port, pin_d = 1'b0;
   logic                 [7:0] rises = 8'h00;
   logic                 [7:0] rdata, rxraw, txb, got, tries, base;
   logic                 [2:0] nacks;
   logic                 [8:0] gtv;
   card_uart_pkg::sfr_req_s    req;
   card_uart_pkg::shifter_ev_s sev;
   card_uart_pkg::irq_src_e    code;
   int                         fail_count, checked;
   logic                 [7:0] ien [6] = '{8'hbf, 8'h10, 8'h08, 8'h02, 8'h01, 8'h00};
   logic                 [2:0] exc [6] = '{3'h2, 3'h3, 3'h4, 3'h6, 3'h7, 3'h0};
   assign sev = {done, nack, rxv, rxp, rxraw};
   card_irq_select_buffer #(.FIFO_DEPTH(32)) u_card_irq_select_buffer (.core_clk, .rst,
      .sfr_req(req), .sfr_rdata_r(rdata), .ev_current_ovf(ovf), .ev_voltage_err(vlt),
      .ev_wait_timeout(wto), .shifter_ev(sev), .inverse_convention(inv),
      .rx_start_edge(rse), .etu_tick(tick), .guard_time_value(gtv), .tx_valid_r(txv),
      .tx_ready(txr), .tx_byte_r(txb), .tx_buffer_empty_flag_r(tbe), .irq_r(irq),
      .irq_code_r(code), .prescaler_source_clock(src), .alt_port_bit(port),
      .alt_card_clock_pin_r(pin));
   card_shifter_model u_card_shifter_model (.core_clk, .rst, .tx_valid(txv), .tx_byte(txb),
      .nacks, .tx_ready(txr), .tx_done(done), .tx_nack(nack), .got, .tries);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // source toggles every cycle; rises counts rising edges seen on the clock pin
   always @(posedge core_clk) begin
      src   <= ~src;
      pin_d <= pin;
      if (pin && !pin_d) begin
         rises <= rises + 8'h01;
      end
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk) req <= '{a, d, 1'b1, 1'b0};
      @(posedge core_clk) req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk) req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge core_clk) req <= '0;
      #1 chk("read data", exp, rdata);
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      {ovf, vlt, wto, rxv, rxp, inv, tick, rse, src} = '0;
      port = 1'b1;
      req = '0;
      rxraw = 8'h00;
      gtv = 9'h000;
      nacks = 3'h0;
      fail_count = 0;
      checked = 0;
      rst = 1'b1;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      rd(8'hab, 8'h08);
      chk("buffer room", 8'h01, {7'h00, tbe});
      chk("clock pin", 8'h01, {7'h00, pin});
      wr(8'hab, 8'h01);
      rd(8'hae, 8'h00);
      wr(8'hae, 8'hff);
      rd(8'hae, 8'hbf);
      @(posedge core_clk) inv <= 1'b1;
      wr(8'haa, 8'h01);
      repeat (30) @(posedge core_clk);
      chk("sent byte", 8'h7f, got);
      chk("irq code", {5'h00, card_uart_pkg::SRC_TBE}, {5'h00, code});
      wr(8'hab, 8'h00);
      rd(8'hae, 8'h84);
      rd(8'hae, 8'h00);
      // limit of five: four refusals then success
      @(posedge core_clk) inv <= 1'b0;
      nacks <= 3'h4;
      base = tries;
      wr(8'haa, 8'h5a);
      repeat (70) @(posedge core_clk);
      chk("attempts", 8'h05, tries - base);
      rd(8'hae, 8'h84);
      @(posedge core_clk) nacks <= 3'h7;
      wr(8'hab, 8'h10);
      base = tries;
      wr(8'haa, 8'h3c);
      repeat (70) @(posedge core_clk);
      chk("attempts", 8'h04, tries - base);
      rd(8'hae, 8'h81);
      @(posedge core_clk) {ovf, vlt, wto, rxv, rxp, rxraw} <= {5'h1f, 8'hc3};
      @(posedge core_clk) {ovf, vlt, wto, rxv, rxp} <= 5'h00;
      rd(8'haa, 8'hc3);
      wr(8'hab, 8'h01);
      for (int i = 0; i < 6; i++) begin
         wr(8'hae, ien[i]);
         repeat (2) @(posedge core_clk);
         #1 chk("irq code", {5'h00, exc[i]}, {5'h00, code});
         chk("irq line", {7'h00, i < 5}, {7'h00, irq});
      end
      wr(8'hab, 8'h00);
      rd(8'hae, 8'h3b);
      // guard hold: three ticks, restarted by a received start bit
      @(posedge core_clk) nacks <= 3'h0;
      gtv <= 9'h003;
      wr(8'hab, 8'h40);
      base = tries;
      wr(8'haa, 8'h11);
      repeat (8) @(posedge core_clk);
      chk("held offer", 8'h00, tries - base);
      tick <= 1'b1;
      repeat (2) @(posedge core_clk);
      {tick, rse} <= 2'b01;
      @(posedge core_clk) {tick, rse} <= 2'b10;
      repeat (2) @(posedge core_clk);
      tick <= 1'b0;
      repeat (8) @(posedge core_clk);
      chk("reloaded hold", 8'h00, tries - base);
      tick <= 1'b1;
      @(posedge core_clk) tick <= 1'b0;
      repeat (30) @(posedge core_clk);
      chk("sent byte", 8'h11, got);
      chk("attempts", 8'h01, tries - base);
      // source rises every 2 cycles, so factor f gives 32/f pin rises in 64 cycles
      for (int d = 0; d < 4; d++) begin
         wr(8'hab, {4'h0, 2'(d), 2'b10});
         repeat (20) @(posedge core_clk);
         base = rises;
         repeat (64) @(posedge core_clk);
         chk("clock rises", 8'h20 >> d, rises - base);
      end
      wr(8'hab, 8'h00);
      port <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("clock pin", 8'h00, {7'h00, pin});
      end_sim;
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      fail_count++;
      end_sim;
   end
endmodule
`default_nettype wire
